// >>> hw/timer8_params.svh
`ifndef TIMER8_PARAMS_SVH
`define TIMER8_PARAMS_SVH

// ==========================================================
// Register offsets
`define OFS_CONTROL_A 4'h0
`define OFS_CONTROL_B 4'h1
`define OFS_COUNT 4'h2
`define OFS_COMPARE_A 4'h3
`define OFS_COMPARE_B 4'h4
`define OFS_FLAGS 4'h5
`define OFS_MASK 4'h6

// ==========================================================
// Field positions
`define POS_WGM_LO 0
`define POS_WGM_HI 3
`define POS_CS 0
`define POS_OVF 0
`define POS_CMPA 1
`define POS_CMPB 2

// ==========================================================
// Reset values and fixed counts
`define RST_BYTE 8'h00
`define VAL_BOTTOM 8'h00
`define VAL_MAX 8'hff

`endif

// >>> hw/timer8_pkg.sv
package timer8_pkg;
   typedef enum logic [2:0] {
      CS_STOP, CS_DIV1, CS_DIV8, CS_DIV64, CS_DIV256, CS_DIV1024, CS_EXT_FALL, CS_EXT_RISE
   } clock_sel_type;
   typedef enum logic [2:0] {
      WM_NORMAL, WM_PWM_PC, WM_CTC, WM_PWM_FAST, WM_RSV4, WM_PWM_PC_TOP, WM_RSV6, WM_PWM_FAST_TOP
   } wave_mode_type;
endpackage

// >>> hw/timer8.sv
// Behaviour
// - Count and both compare registers are eight bits.
// - Overflow and compare requests show in flag register, each masked separately.
// - Tick comes from internal prescaler or external count pin.
// - Clock select picks tick source and active edge.
// - Three-bit clock select in control B; zero stops the counter.
// - Compare registers compared with count on each tick; result drives two compare output pins.
// - Match on unit A or B sets its compare flag.
// - Bottom recognised when count is zero.
// - Max recognised when count is 0xff.
// - Top is 0xff or compare A, chosen by mode.
// - Each tick clears, increments or decrements count per mode and direction.
// - CPU may read and write count at any time.
// - CPU write to count wins over clear or count.
// - Three-bit waveform mode, two low bits in control A, high bit in B.
// - Overflow flag set per mode and raises an interrupt request.
// - Compare registers double buffered in PWM modes, updated at defined point.
// - Counter gives top and bottom indications to waveform logic.
// - Compare match sets its flag on the tick after the match.
// - Compare flag cleared by service acknowledge or by writing one.
// - CPU write to count blocks compare matches in the next tick.
// - Mode zero counts up, wraps 0xff to zero, sets overflow at zero.
`timescale 1ns/1ps
`include "timer8_params.svh"

module timer8 #(
   parameter int PRESCALE_WIDTH = 10
) (
   // Clock and reset
   input wire logic CLOCK_IN,
   input wire logic RST_N_IN,
   // Register port
   input wire logic [3:0] ADDR_IN,
   input wire logic [7:0] WDATA_IN,
   input wire logic WRITE_IN,
   input wire logic READ_IN,
   output logic [7:0] RDATA_OUT,
   // Interrupt service acknowledge, one pulse per source
   input wire logic OVF_ACK_IN,
   input wire logic CMPA_ACK_IN,
   input wire logic CMPB_ACK_IN,
   // External count pin
   input wire logic EXT_COUNT_IN,
   // Requests and waveform outputs
   output logic OVF_IRQ_OUT,
   output logic CMPA_IRQ_OUT,
   output logic CMPB_IRQ_OUT,
   output logic COMPARE_A_OUT,
   output logic COMPARE_B_OUT
);

   // ==========================================================
   // Registers
   logic [7:0] control_a_q;
   logic [7:0] control_b_q;
   logic [7:0] count_q;
   logic [7:0] cmp_buf_a_q;
   logic [7:0] cmp_buf_b_q;
   logic [7:0] cmp_a_q;
   logic [7:0] cmp_b_q;
   logic [2:0] flags_q;
   logic [2:0] mask_q;
   logic down_q;
   logic block_q;
   logic [PRESCALE_WIDTH-1:0] prescale_q;
   logic [2:0] ext_sync_q;
   logic ext_prev_q;
   logic cmpa_hit_q;
   logic cmpb_hit_q;
   logic wave_a_q;
   logic wave_b_q;
   logic [7:0] rdata_q;

   timer8_pkg::clock_sel_type clock_sel;
   timer8_pkg::wave_mode_type wave_mode;
   logic pwm_mode;
   logic tick;
   logic [7:0] top_val;
   logic at_top;
   logic at_bottom;
   logic at_max;
   logic count_wr;
   logic [7:0] count_d;
   logic down_d;
   logic ovf_set;
   logic ext_level;

   function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs, input logic wr);
      hit = wr && (a == ofs);
   endfunction

   assign clock_sel = timer8_pkg::clock_sel_type'(control_b_q[`POS_CS +: 3]);
   assign wave_mode = timer8_pkg::wave_mode_type'({control_b_q[`POS_WGM_HI],
      control_a_q[`POS_WGM_LO +: 2]});
   assign pwm_mode = wave_mode == timer8_pkg::WM_PWM_PC || wave_mode == timer8_pkg::WM_PWM_FAST ||
      wave_mode == timer8_pkg::WM_PWM_PC_TOP || wave_mode == timer8_pkg::WM_PWM_FAST_TOP;
   assign count_wr = hit(ADDR_IN, `OFS_COUNT, WRITE_IN);

   // ==========================================================
   // Prescaler and tick select
   always_ff @(posedge CLOCK_IN) begin
      if (!RST_N_IN) begin
         prescale_q <= '0;
      end else begin
         prescale_q <= prescale_q + 1'b1;
      end
   end

   always_ff @(posedge CLOCK_IN) begin
      if (!RST_N_IN) begin
         ext_sync_q <= 3'h0;
         ext_prev_q <= 1'b0;
      end else begin
         ext_sync_q <= {ext_sync_q[1:0], EXT_COUNT_IN};
         if (ext_sync_q[1] == ext_sync_q[2]) begin
            ext_prev_q <= ext_sync_q[2];
         end
      end
   end
   assign ext_level = (ext_sync_q[1] == ext_sync_q[2]) ? ext_sync_q[2] : ext_prev_q;

   always_comb begin
      unique case (clock_sel)
         timer8_pkg::CS_STOP: tick = 1'b0;
         timer8_pkg::CS_DIV1: tick = 1'b1;
         timer8_pkg::CS_DIV8: tick = &prescale_q[2:0];
         timer8_pkg::CS_DIV64: tick = &prescale_q[5:0];
         timer8_pkg::CS_DIV256: tick = &prescale_q[7:0];
         timer8_pkg::CS_DIV1024: tick = &prescale_q[9:0];
         timer8_pkg::CS_EXT_FALL: tick = ext_prev_q && !ext_level;
         timer8_pkg::CS_EXT_RISE: tick = !ext_prev_q && ext_level;
      endcase
   end

   // ==========================================================
   // Counter unit
   always_comb begin
      unique case (wave_mode)
         timer8_pkg::WM_CTC, timer8_pkg::WM_PWM_PC_TOP, timer8_pkg::WM_PWM_FAST_TOP: top_val = cmp_a_q;
         default: top_val = `VAL_MAX;
      endcase
   end
   assign at_top = count_q == top_val;
   assign at_bottom = count_q == `VAL_BOTTOM;
   assign at_max = count_q == `VAL_MAX;

   always_comb begin
      count_d = count_q;
      down_d = down_q;
      ovf_set = 1'b0;
      if (tick) begin
         unique case (wave_mode)
            timer8_pkg::WM_PWM_PC, timer8_pkg::WM_PWM_PC_TOP: begin
               if (at_top) begin
                  down_d = 1'b1;
                  count_d = count_q - 8'h01;
               end else if (at_bottom) begin
                  down_d = 1'b0;
                  count_d = count_q + 8'h01;
               end else begin
                  count_d = down_q ? count_q - 8'h01 : count_q + 8'h01;
               end
               ovf_set = at_bottom;
            end
            timer8_pkg::WM_CTC, timer8_pkg::WM_PWM_FAST, timer8_pkg::WM_PWM_FAST_TOP: begin
               down_d = 1'b0;
               count_d = at_top ? `VAL_BOTTOM : count_q + 8'h01;
               ovf_set = wave_mode == timer8_pkg::WM_CTC ? at_max : at_top;
            end
            default: begin
               down_d = 1'b0;
               count_d = count_q + 8'h01;
               ovf_set = at_max;
            end
         endcase
      end
      if (count_wr) begin
         count_d = WDATA_IN;
      end
   end

   always_ff @(posedge CLOCK_IN) begin
      if (!RST_N_IN) begin
         count_q <= `RST_BYTE;
         down_q <= 1'b0;
      end else begin
         count_q <= count_d;
         down_q <= down_d;
      end
   end

   // ==========================================================
   // Control, mask and compare registers
   always_ff @(posedge CLOCK_IN) begin
      if (!RST_N_IN) begin
         control_a_q <= `RST_BYTE;
         control_b_q <= `RST_BYTE;
         mask_q <= 3'h0;
         cmp_buf_a_q <= `RST_BYTE;
         cmp_buf_b_q <= `RST_BYTE;
      end else begin
         if (hit(ADDR_IN, `OFS_CONTROL_A, WRITE_IN)) control_a_q <= WDATA_IN;
         if (hit(ADDR_IN, `OFS_CONTROL_B, WRITE_IN)) control_b_q <= WDATA_IN;
         if (hit(ADDR_IN, `OFS_MASK, WRITE_IN)) mask_q <= WDATA_IN[2:0];
         if (hit(ADDR_IN, `OFS_COMPARE_A, WRITE_IN)) cmp_buf_a_q <= WDATA_IN;
         if (hit(ADDR_IN, `OFS_COMPARE_B, WRITE_IN)) cmp_buf_b_q <= WDATA_IN;
      end
   end

   // Active compare copies load at top in PWM modes, at once otherwise
   always_ff @(posedge CLOCK_IN) begin
      if (!RST_N_IN) begin
         cmp_a_q <= `RST_BYTE;
         cmp_b_q <= `RST_BYTE;
      end else if (!pwm_mode || (tick && at_top)) begin
         cmp_a_q <= cmp_buf_a_q;
         cmp_b_q <= cmp_buf_b_q;
      end
   end

   // ==========================================================
   // Compare match and flags
   always_ff @(posedge CLOCK_IN) begin
      if (!RST_N_IN) begin
         block_q <= 1'b0;
         cmpa_hit_q <= 1'b0;
         cmpb_hit_q <= 1'b0;
      end else begin
         if (count_wr) begin
            block_q <= 1'b1;
         end else if (tick) begin
            block_q <= 1'b0;
         end
         // A count write also drops a match still waiting for its flag
         if (count_wr) begin
            cmpa_hit_q <= 1'b0;
            cmpb_hit_q <= 1'b0;
         end else if (tick) begin
            cmpa_hit_q <= !block_q && count_q == cmp_a_q;
            cmpb_hit_q <= !block_q && count_q == cmp_b_q;
         end
      end
   end

   logic [2:0] flag_set;
   logic [2:0] flag_clr;
   assign flag_set = {tick & cmpb_hit_q, tick & cmpa_hit_q, ovf_set};
   assign flag_clr = {CMPB_ACK_IN, CMPA_ACK_IN, OVF_ACK_IN} |
      (hit(ADDR_IN, `OFS_FLAGS, WRITE_IN) ? WDATA_IN[2:0] : 3'h0);

   always_ff @(posedge CLOCK_IN) begin
      if (!RST_N_IN) begin
         flags_q <= 3'h0;
      end else begin
         flags_q <= (flags_q & ~flag_clr) | flag_set;
      end
   end

   assign OVF_IRQ_OUT = flags_q[`POS_OVF] & mask_q[`POS_OVF];
   assign CMPA_IRQ_OUT = flags_q[`POS_CMPA] & mask_q[`POS_CMPA];
   assign CMPB_IRQ_OUT = flags_q[`POS_CMPB] & mask_q[`POS_CMPB];

   // ==========================================================
   // Waveform outputs: toggle on match, PWM set/clear otherwise
   always_ff @(posedge CLOCK_IN) begin
      if (!RST_N_IN) begin
         wave_a_q <= 1'b0;
         wave_b_q <= 1'b0;
      end else if (tick) begin
         if (pwm_mode) begin
            wave_a_q <= count_d < cmp_a_q;
            wave_b_q <= count_d < cmp_b_q;
         end else begin
            if (!block_q && count_q == cmp_a_q) wave_a_q <= !wave_a_q;
            if (!block_q && count_q == cmp_b_q) wave_b_q <= !wave_b_q;
         end
      end
   end
   assign COMPARE_A_OUT = wave_a_q;
   assign COMPARE_B_OUT = wave_b_q;

   // ==========================================================
   // Read port
   always_ff @(posedge CLOCK_IN) begin
      if (!RST_N_IN) begin
         rdata_q <= 8'h00;
      end else if (READ_IN) begin
         unique case (ADDR_IN)
            `OFS_CONTROL_A: rdata_q <= control_a_q;
            `OFS_CONTROL_B: rdata_q <= control_b_q;
            `OFS_COUNT: rdata_q <= count_q;
            `OFS_COMPARE_A: rdata_q <= cmp_buf_a_q;
            `OFS_COMPARE_B: rdata_q <= cmp_buf_b_q;
            `OFS_FLAGS: rdata_q <= {5'h00, flags_q};
            `OFS_MASK: rdata_q <= {5'h00, mask_q};
            default: rdata_q <= 8'h00;
         endcase
      end else begin
         rdata_q <= 8'h00;
      end
   end
   assign RDATA_OUT = rdata_q;

   // ==========================================================
   // Checks
   stop_holds_a: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
      clock_sel == timer8_pkg::CS_STOP && !count_wr |=> $stable(count_q))
      else $error("count moved while stopped");
   write_wins_a: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
      count_wr |=> count_q == $past(WDATA_IN))
      else $error("count write lost");
   normal_wrap_a: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
      wave_mode == timer8_pkg::WM_NORMAL && tick && at_max && !count_wr |=> count_q == 8'h00 && flags_q[0])
      else $error("normal wrap wrong");
   flag_set_a: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
      tick && cmpa_hit_q |=> flags_q[1])
      else $error("compare flag not set");
   block_after_write_a: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
      count_wr |=> !cmpa_hit_q && !cmpb_hit_q)
      else $error("match not blocked");
   flag_clear_a: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
      CMPA_ACK_IN && !(tick && cmpa_hit_q) |=> !flags_q[1])
      else $error("flag not cleared");
   irq_mask_a: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
      !mask_q[0] |-> !OVF_IRQ_OUT)
      else $error("masked overflow request");
   ctc_clear_a: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
      wave_mode == timer8_pkg::WM_CTC && tick && at_top && !count_wr |=> count_q == 8'h00)
      else $error("ctc did not clear");
   stale_cmp_a: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
      pwm_mode && !(tick && at_top) |=> $stable(cmp_a_q))
      else $error("compare updated mid period");
   flag_b_set_a: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
      tick && cmpb_hit_q |=> flags_q[2])
      else $error("compare b flag not set");
   pc_turn_a: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
      wave_mode == timer8_pkg::WM_PWM_PC && tick && at_top && !count_wr |=> down_q && count_q == 8'hfe)
      else $error("phase correct did not turn");
   fast_top_a: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
      wave_mode == timer8_pkg::WM_PWM_FAST_TOP && tick && at_top && !count_wr |=> count_q == 8'h00)
      else $error("fast top did not restart");
   bottom_ovf_a: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
      wave_mode == timer8_pkg::WM_PWM_PC && tick && at_bottom |=> flags_q[0])
      else $error("phase correct overflow missing");
   ovf_cov: cover property (@(posedge CLOCK_IN) flags_q[0]);
   cmpa_cov: cover property (@(posedge CLOCK_IN) flags_q[1] && mask_q[1]);
   pc_cov: cover property (@(posedge CLOCK_IN) wave_mode == timer8_pkg::WM_PWM_PC && down_q);
   cmpb_cov: cover property (@(posedge CLOCK_IN) flags_q[2] && mask_q[2]);
   fast_top_cov: cover property (@(posedge CLOCK_IN) wave_mode == timer8_pkg::WM_PWM_FAST_TOP && tick && at_top);

endmodule

// >>> verif/tb_top.sv
`timescale 1ns/1ps
`include "timer8_params.svh"

`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin n_errors++; \
   $display("Error %s expected %h seen %h", nm, ex, got); end end

module tb_top;
   // ==========================================================
   // Clock, reset and design
   logic CLOCK_IN = 1'b0;
   logic RST_N_IN = 1'b0;
   logic [3:0] ADDR_IN = 4'h0;
   logic [7:0] WDATA_IN = 8'h00;
   logic WRITE_IN = 1'b0;
   logic READ_IN = 1'b0;
   logic OVF_ACK_IN = 1'b0;
   logic CMPA_ACK_IN = 1'b0;
   logic CMPB_ACK_IN = 1'b0;
   logic EXT_COUNT_IN = 1'b0;
   logic [7:0] RDATA_OUT;
   logic OVF_IRQ_OUT, CMPA_IRQ_OUT, CMPB_IRQ_OUT, COMPARE_A_OUT, COMPARE_B_OUT;
   int n_errors = 0;
   int total_checks = 0;
   logic [7:0] d;
   int hi;
   int hi_b;

   always #25 CLOCK_IN = ~CLOCK_IN;

   timer8 timer8_inst (.CLOCK_IN(CLOCK_IN), .RST_N_IN(RST_N_IN), .ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN),
      .WRITE_IN(WRITE_IN), .READ_IN(READ_IN), .RDATA_OUT(RDATA_OUT), .OVF_ACK_IN(OVF_ACK_IN),
      .CMPA_ACK_IN(CMPA_ACK_IN), .CMPB_ACK_IN(CMPB_ACK_IN), .EXT_COUNT_IN(EXT_COUNT_IN),
      .OVF_IRQ_OUT(OVF_IRQ_OUT), .CMPA_IRQ_OUT(CMPA_IRQ_OUT), .CMPB_IRQ_OUT(CMPB_IRQ_OUT),
      .COMPARE_A_OUT(COMPARE_A_OUT), .COMPARE_B_OUT(COMPARE_B_OUT));

   // ==========================================================
   // Register port tasks
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge CLOCK_IN);
      WRITE_IN <= 1'b1;
      ADDR_IN <= a;
      WDATA_IN <= v;
      @(posedge CLOCK_IN);
      WRITE_IN <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a, output logic [7:0] v);
      @(posedge CLOCK_IN);
      READ_IN <= 1'b1;
      ADDR_IN <= a;
      @(posedge CLOCK_IN);
      READ_IN <= 1'b0;
      @(negedge CLOCK_IN);
      v = RDATA_OUT;
   endtask

   task automatic rchk(input logic [3:0] a, input logic [7:0] ex);
      rd(a, d);
      `CHK("register", ex, d)
   endtask

   task automatic cfg(input logic [2:0] mode, input logic [2:0] cs);
      wr(`OFS_CONTROL_A, {6'h00, mode[1:0]});
      wr(`OFS_CONTROL_B, {4'h0, mode[2], cs});
   endtask

   task automatic ack(input int which);
      @(posedge CLOCK_IN);
      if (which == 0) OVF_ACK_IN <= 1'b1; else if (which == 1) CMPA_ACK_IN <= 1'b1; else CMPB_ACK_IN <= 1'b1;
      @(posedge CLOCK_IN);
      OVF_ACK_IN <= 1'b0;
      CMPA_ACK_IN <= 1'b0;
      CMPB_ACK_IN <= 1'b0;
      @(negedge CLOCK_IN);
   endtask

   task automatic test_done;
      $display("Checks %0d mismatches %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   initial begin
      repeat (30000) @(posedge CLOCK_IN);
      n_errors++;
      test_done();
   end

   // ==========================================================
   // Tests
   initial begin
      repeat (2) @(posedge CLOCK_IN);
      RST_N_IN <= 1'b1;
      for (int a = 0; a < 8; a++) begin
         rchk(a[3:0], `RST_BYTE);
      end
      wr(4'h7, 8'h5a);
      rchk(4'h7, 8'h00);
      wr(`OFS_COMPARE_A, 8'ha5);
      rchk(`OFS_COMPARE_A, 8'ha5);
      wr(`OFS_COMPARE_B, 8'h3c);
      rchk(`OFS_COMPARE_B, 8'h3c);
      // Stopped counter keeps a written value
      wr(`OFS_COUNT, 8'h55);
      repeat (20) @(posedge CLOCK_IN);
      rchk(`OFS_COUNT, 8'h55);
      // Overflow in normal mode, mask and both clear paths
      wr(`OFS_MASK, 8'h01);
      wr(`OFS_COUNT, 8'hfd);
      cfg(3'h0, 3'h1);
      repeat (10) @(posedge CLOCK_IN);
      rd(`OFS_FLAGS, d);
      `CHK("overflow flag", 1'b1, d[`POS_OVF])
      `CHK("overflow irq", 1'b1, OVF_IRQ_OUT)
      wr(`OFS_MASK, 8'h00);
      @(negedge CLOCK_IN);
      `CHK("masked irq", 1'b0, OVF_IRQ_OUT)
      wr(`OFS_MASK, 8'h07);
      wr(`OFS_FLAGS, 8'h01);
      @(negedge CLOCK_IN);
      `CHK("cleared irq", 1'b0, OVF_IRQ_OUT)
      repeat (260) @(posedge CLOCK_IN);
      @(negedge CLOCK_IN);
      `CHK("second overflow", 1'b1, OVF_IRQ_OUT)
      ack(0);
      `CHK("acked overflow", 1'b0, OVF_IRQ_OUT)
      // Compare matches on both units
      cfg(3'h0, 3'h0);
      wr(`OFS_COMPARE_A, 8'h40);
      wr(`OFS_COMPARE_B, 8'h48);
      wr(`OFS_COUNT, 8'h30);
      wr(`OFS_FLAGS, 8'h07);
      cfg(3'h0, 3'h1);
      repeat (40) @(posedge CLOCK_IN);
      rchk(`OFS_FLAGS, 8'h06);
      `CHK("irq a", 1'b1, CMPA_IRQ_OUT)
      ack(1);
      `CHK("irq a acked", 1'b0, CMPA_IRQ_OUT)
      `CHK("irq b", 1'b1, CMPB_IRQ_OUT)
      ack(2);
      `CHK("irq b acked", 1'b0, CMPB_IRQ_OUT)
      rchk(`OFS_FLAGS, 8'h00);
      // A count write equal to compare B blocks the next match
      cfg(3'h0, 3'h0);
      wr(`OFS_COMPARE_B, 8'h20);
      wr(`OFS_COUNT, 8'h20);
      cfg(3'h0, 3'h1);
      repeat (10) @(posedge CLOCK_IN);
      rchk(`OFS_FLAGS, 8'h00);
      // Count write wins over counting
      @(posedge CLOCK_IN);
      WRITE_IN <= 1'b1;
      ADDR_IN <= `OFS_COUNT;
      WDATA_IN <= 8'h99;
      @(posedge CLOCK_IN);
      WRITE_IN <= 1'b0;
      READ_IN <= 1'b1;
      @(posedge CLOCK_IN);
      READ_IN <= 1'b0;
      @(negedge CLOCK_IN);
      `CHK("count after write", 8'h99, RDATA_OUT)
      // Clear on compare keeps the count at or below compare A
      cfg(3'h0, 3'h0);
      wr(`OFS_COMPARE_A, 8'h05);
      wr(`OFS_COUNT, 8'h00);
      cfg(3'h2, 3'h1);
      for (int i = 0; i < 4; i++) begin
         repeat (7 + i) @(posedge CLOCK_IN);
         rd(`OFS_COUNT, d);
         `CHK("ctc bound", 1'b1, d <= 8'h05)
      end
      // Prescaled tick, divide by eight
      cfg(3'h0, 3'h0);
      wr(`OFS_COUNT, 8'h00);
      wr(`OFS_CONTROL_B, 8'h02);
      repeat (79) @(posedge CLOCK_IN);
      rd(`OFS_COUNT, d);
      `CHK("divide by eight", 1'b1, d >= 8'h09 && d <= 8'h0b)
      // External pin, falling then rising edge
      for (int cs = 6; cs < 8; cs++) begin
         cfg(3'h0, cs[2:0]);
         wr(`OFS_COUNT, 8'h00);
         for (int p = 0; p < 5; p++) begin
            repeat (4) @(posedge CLOCK_IN);
            EXT_COUNT_IN <= 1'b1;
            repeat (4) @(posedge CLOCK_IN);
            EXT_COUNT_IN <= 1'b0;
         end
         repeat (8) @(posedge CLOCK_IN);
         rchk(`OFS_COUNT, 8'h05);
         @(posedge CLOCK_IN);
         EXT_COUNT_IN <= 1'b1;
         repeat (8) @(posedge CLOCK_IN);
         rchk(`OFS_COUNT, (cs == 6) ? 8'h05 : 8'h06);
         @(posedge CLOCK_IN);
         EXT_COUNT_IN <= 1'b0;
         repeat (8) @(posedge CLOCK_IN);
      end
      // Fast PWM, half duty on A, one eighth duty on B
      cfg(3'h3, 3'h0);
      wr(`OFS_COMPARE_A, 8'h80);
      cfg(3'h3, 3'h1);
      repeat (300) @(posedge CLOCK_IN);
      hi = 0;
      hi_b = 0;
      for (int i = 0; i < 512; i++) begin
         @(negedge CLOCK_IN);
         if (COMPARE_A_OUT === 1'b1) hi++;
         if (COMPARE_B_OUT === 1'b1) hi_b++;
      end
      `CHK("pwm duty", 1'b1, hi >= 252 && hi <= 260)
      `CHK("pwm duty b", 1'b1, hi_b >= 60 && hi_b <= 68)
      // Phase correct turns at 0xff; fast PWM wraps at compare A
      cfg(3'h0, 3'h0);
      wr(`OFS_COUNT, 8'hfa);
      cfg(3'h1, 3'h1);
      repeat (10) @(posedge CLOCK_IN);
      rchk(`OFS_COUNT, 8'hf9);
      cfg(3'h0, 3'h0);
      wr(`OFS_COUNT, 8'h00);
      cfg(3'h7, 3'h1);
      repeat (200) @(posedge CLOCK_IN);
      rchk(`OFS_COUNT, 8'h48);
      test_done();
   end
endmodule
